// *** shared/fspc_map.svh ***
// Constants for the flash self-program access controller.
// Included by the design files; no logic here.
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH
`define FSPC_ADDR_W 13
`define FSPC_HALT_BASE 13'h1C00
// Loader base per fuse code; every base sits at or above the halting base
`define FSPC_LDR_BASE_F3 13'h1F80
`define FSPC_LDR_BASE_F2 13'h1F00
`define FSPC_LDR_BASE_F1 13'h1E00
`define FSPC_LDR_BASE_F0 13'h1C00
`define FSPC_REG_CTL 3'h0
`define FSPC_REG_LOCK 3'h1
`define FSPC_REG_STAT 3'h2
`define FSPC_REG_MASK 3'h3
`define FSPC_OP_TIME_US 4500
`define FSPC_CLK_MHZ 125
`define FSPC_OP_CYCLES (`FSPC_OP_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_CTL_ENABLE 0
`define FSPC_CTL_ERASE 1
`define FSPC_CTL_WRITE 2
`define FSPC_CTL_LOCKSET 3
`define FSPC_CTL_REENABLE 4
`define FSPC_CTL_BUSY 6
`define FSPC_CTL_IE 7
`define FSPC_CTL_RESET 8'h00
`define FSPC_LOCK_RESET 2'h3
`endif

// *** shared/fspc_pkg.sv ***
// Types for the flash self-program access controller.
// Constants live in fspc_map.svh.
package fspc_pkg;
	typedef enum logic [1:0] {
		FSPC_OP_NONE,
		FSPC_OP_ERASE,
		FSPC_OP_WRITE,
		FSPC_OP_LOAD
	} fspc_op_t;
	typedef enum logic [1:0] {
		FSPC_IDLE,
		FSPC_CONC,
		FSPC_HALT
	} fspc_state_t;
endpackage

// *** hdl/fspc_section_decode.sv ***
// Address section decoder: loader section and halting section membership.
// Assumes a word address and loader size fuses sampled as static levels.
`timescale 1ns/10ps
`include "fspc_map.svh"
module fspc_section_decode #(
	parameter int ADDR_W = `FSPC_ADDR_W
) (
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [1:0] loader_size_fuses,
	output logic in_loader,
	output logic in_halting
);
	logic [ADDR_W-1:0] loader_base;
	assign loader_base = (loader_size_fuses == 2'h3) ? ADDR_W'(`FSPC_LDR_BASE_F3) :
		(loader_size_fuses == 2'h2) ? ADDR_W'(`FSPC_LDR_BASE_F2) :
		(loader_size_fuses == 2'h1) ? ADDR_W'(`FSPC_LDR_BASE_F1) :
		ADDR_W'(`FSPC_LDR_BASE_F0);
	assign in_loader = (addr >= loader_base);
	assign in_halting = (addr >= ADDR_W'(`FSPC_HALT_BASE));
endmodule // fspc_section_decode

// *** hdl/fspc_timer.sv ***
// Programming-time counter: counts an erase or write to its end.
// Assumes start pulses only while idle.
`timescale 1ns/10ps
`include "fspc_map.svh"
module fspc_timer #(
	parameter int CYCLES = `FSPC_OP_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	output logic running,
	output logic done
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic running_reg;
	logic done_reg;
	assign count_next = start ? 32'(CYCLES) : (count_reg - 32'h1);
	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg <= 32'h0;
			running_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= running_reg && !start && (count_reg == 32'h1);
			if (start || running_reg) begin
				count_reg <= count_next;
			end
			if (start) begin
				running_reg <= 1'b1;
			end else if (running_reg && count_reg == 32'h1) begin
				running_reg <= 1'b0;
			end
		end
	end
	assign running = running_reg;
	assign done = done_reg;
endmodule // fspc_timer

// *** hdl/fspc_ctrl.sv ***
// Flash self-program access controller: gates store-program requests,
// times page erase and write, stalls the CPU or blocks the concurrent
// section, and holds the self-program control register.
// Assumes one-cycle request pulses from the CPU core, synchronous to clock.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "fspc_map.svh"
module fspc_ctrl #(
	parameter int ADDR_W = `FSPC_ADDR_W,
	parameter int OP_CYCLES = `FSPC_OP_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic store_program_instr,
	input wire logic [ADDR_W-1:0] pc_addr,
	input wire logic [ADDR_W-1:0] target_addr,
	input wire logic [1:0] loader_size_fuses,
	input wire logic load_program_instr,
	input wire logic [ADDR_W-1:0] load_addr,
	output logic cpu_stall,
	output logic concurrent_section_busy,
	output logic load_blocked,
	output logic program_done,
	output logic irq
);
	localparam logic [2:0] ADDR_CTL = `FSPC_REG_CTL;
	localparam logic [2:0] ADDR_LOCK = `FSPC_REG_LOCK;
	localparam logic [2:0] ADDR_STAT = `FSPC_REG_STAT;
	localparam logic [2:0] ADDR_MASK = `FSPC_REG_MASK;

	fspc_pkg::fspc_state_t state_reg;
	fspc_pkg::fspc_state_t state_next;
	logic [7:0] ctl_reg;
	logic [1:0] application_lock_set_reg;
	logic [1:0] loader_lock_set_reg;
	logic busy_reg;
	logic busy_next;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [1:0] mask_reg;
	logic [7:0] rdata_reg;
	logic stall_reg;
	logic blocked_reg;
	logic done_reg;
	logic irq_reg;

	logic pc_in_loader;
	logic tgt_in_loader;
	logic tgt_in_halting;
	logic load_in_halting;
	logic timer_running;
	logic timer_done;

	fspc_section_decode #(.ADDR_W(ADDR_W)) u_pc_dec (
		.addr(pc_addr),
		.loader_size_fuses(loader_size_fuses),
		.in_loader(pc_in_loader),
		.in_halting()
	);
	fspc_section_decode #(.ADDR_W(ADDR_W)) u_tgt_dec (
		.addr(target_addr),
		.loader_size_fuses(loader_size_fuses),
		.in_loader(tgt_in_loader),
		.in_halting(tgt_in_halting)
	);
	fspc_section_decode #(.ADDR_W(ADDR_W)) u_load_dec (
		.addr(load_addr),
		.loader_size_fuses(loader_size_fuses),
		.in_loader(),
		.in_halting(load_in_halting)
	);

	// Decode of a store-program request
	wire idle = (state_reg == fspc_pkg::FSPC_IDLE);
	wire store_ok = store_program_instr && pc_in_loader && idle && ctl_reg[`FSPC_CTL_ENABLE];
	wire want_erase = ctl_reg[`FSPC_CTL_ERASE];
	wire want_write = ctl_reg[`FSPC_CTL_WRITE];
	wire want_lock = ctl_reg[`FSPC_CTL_LOCKSET];
	wire want_page = want_erase || want_write;
	wire want_load = !want_page && !want_lock && !ctl_reg[`FSPC_CTL_REENABLE];
	// Write protection from the two lock sets, each guarding its own section
	wire app_locked = !application_lock_set_reg[0];
	wire ldr_locked = !loader_lock_set_reg[0];
	wire tgt_locked = tgt_in_loader ? ldr_locked : app_locked;
	wire page_start = store_ok && want_page && !tgt_locked;
	wire start_halt = page_start && tgt_in_halting;
	wire start_conc = page_start && !tgt_in_halting;
	wire lock_start = store_ok && want_lock;
	wire load_start = store_ok && want_load;
	wire reenable_start = store_ok && ctl_reg[`FSPC_CTL_REENABLE];
	wire ctl_wr = reg_write && (reg_addr == ADDR_CTL);
	wire stat_wr = reg_write && (reg_addr == ADDR_STAT);

	fspc_timer #(.CYCLES(OP_CYCLES)) u_timer (
		.clock(clock),
		.rst(rst),
		.start(start_halt || start_conc),
		.running(timer_running),
		.done(timer_done)
	);

	// Operation sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			fspc_pkg::FSPC_IDLE: begin
				if (start_halt) begin
					state_next = fspc_pkg::FSPC_HALT;
				end else if (start_conc) begin
					state_next = fspc_pkg::FSPC_CONC;
				end
			end
			fspc_pkg::FSPC_CONC: begin
				if (timer_done) begin
					state_next = fspc_pkg::FSPC_IDLE;
				end
			end
			fspc_pkg::FSPC_HALT: begin
				if (timer_done) begin
					state_next = fspc_pkg::FSPC_IDLE;
				end
			end
			default: begin
				state_next = fspc_pkg::FSPC_IDLE;
			end
		endcase
	end

	// Busy flag: set by a concurrent-section start, cleared by a load request or by a re-enable request once the timer has stopped
	always_comb begin
		busy_next = busy_reg;
		if ((reenable_start && !timer_running) || load_start) begin
			busy_next = 1'b0;
		end
		if (start_conc) begin
			busy_next = 1'b1;
		end
	end

	// Sticky event bits: bit0 operation done, bit1 refused request; set wins
	wire refused = store_program_instr && !store_ok;
	assign status_next = (status_reg & ~(stat_wr ? reg_wdata[1:0] : 2'h0)) |
		{refused, timer_done};

	wire [7:0] ctl_view = {ctl_reg[`FSPC_CTL_IE], busy_reg, 1'b0, ctl_reg[4:0]};
	wire [7:0] rdata_next = (reg_addr == ADDR_CTL) ? ctl_view :
		(reg_addr == ADDR_LOCK) ? {4'h0, loader_lock_set_reg, application_lock_set_reg} :
		(reg_addr == ADDR_STAT) ? {6'h0, status_reg} :
		(reg_addr == ADDR_MASK) ? {6'h0, mask_reg} : 8'h00;
	wire [1:0] app_lock_next = application_lock_set_reg & ~reg_wdata[1:0];
	wire [1:0] ldr_lock_next = loader_lock_set_reg & ~reg_wdata[3:2];

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= fspc_pkg::FSPC_IDLE;
			busy_reg <= 1'b0;
			status_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			busy_reg <= busy_next;
			status_reg <= status_next;
		end
	end

	// Control register; command bits self-clear once a request is taken or done
	always_ff @(posedge clock) begin
		if (rst) begin
			ctl_reg <= `FSPC_CTL_RESET;
		end else if (ctl_wr) begin
			ctl_reg <= {reg_wdata[7], 2'h0, reg_wdata[4:0]};
		end else if (timer_done || (store_ok && !want_page) || refused) begin
			ctl_reg <= {ctl_reg[7], 7'h00};
		end
	end

	// Lock sets: programmed (cleared) by software through a lock-set request
	always_ff @(posedge clock) begin
		if (rst) begin
			application_lock_set_reg <= `FSPC_LOCK_RESET;
			loader_lock_set_reg <= `FSPC_LOCK_RESET;
		end else if (lock_start) begin
			application_lock_set_reg <= app_lock_next;
			loader_lock_set_reg <= ldr_lock_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mask_reg <= 2'h0;
		end else if (reg_write && reg_addr == ADDR_MASK) begin
			mask_reg <= reg_wdata[1:0];
		end
	end

	// Registered outputs
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_reg <= 8'h00;
			stall_reg <= 1'b0;
			blocked_reg <= 1'b0;
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			rdata_reg <= reg_read ? rdata_next : 8'h00;
			stall_reg <= (state_next == fspc_pkg::FSPC_HALT);
			blocked_reg <= load_program_instr && busy_next && !load_in_halting;
			done_reg <= timer_done;
			irq_reg <= |(status_next & mask_reg);
		end
	end

	assign reg_rdata = rdata_reg;
	assign cpu_stall = stall_reg;
	assign concurrent_section_busy = busy_reg;
	assign load_blocked = blocked_reg;
	assign program_done = done_reg;
	assign irq = irq_reg;
endmodule // fspc_ctrl

// *** verif/fspc_ctrl_asserts.sv ***
// Port checker for fspc_ctrl.
// Bound into every fspc_ctrl; sees only its ports.
`timescale 1ns/10ps
module fspc_ctrl_asserts #(
	parameter int OP_CYCLES = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic store_program_instr,
	input wire logic [12:0] pc_addr,
	input wire logic [12:0] target_addr,
	input wire logic load_program_instr,
	input wire logic [12:0] load_addr,
	input wire logic cpu_stall,
	input wire logic concurrent_section_busy,
	input wire logic load_blocked,
	input wire logic program_done
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] stall_cnt;
	always_ff @(posedge clock) begin
		if (rst || !cpu_stall)
			stall_cnt <= 16'h0000;
		else
			stall_cnt <= stall_cnt + 16'h0001;
	end
	property p_stall_len;
		$fell(cpu_stall) |-> stall_cnt == OP_CYCLES + 1;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
	property p_done;
		$fell(cpu_stall) |-> ##[0:1] program_done;
	endproperty
	a_done: assert property (p_done) else $error("no done after stall");
	property p_app;
		store_program_instr && pc_addr < 13'h1800
		|=> !$rose(cpu_stall) && !$rose(concurrent_section_busy);
	endproperty
	a_app: assert property (p_app) else $error("app store started op");
	property p_stall_src;
		$rose(cpu_stall) |-> $past(store_program_instr) && $past(target_addr) >= 13'h1C00;
	endproperty
	a_stall_src: assert property (p_stall_src) else $error("stall without cause");
	property p_busy_src;
		$rose(concurrent_section_busy)
		|-> $past(store_program_instr) && $past(target_addr) < 13'h1C00;
	endproperty
	a_busy_src: assert property (p_busy_src) else $error("busy without cause");
	property p_blk;
		load_program_instr && concurrent_section_busy && load_addr < 13'h1C00 |=> load_blocked;
	endproperty
	a_blk: assert property (p_blk) else $error("load not blocked");
	property p_blk_src;
		load_blocked |-> $past(load_program_instr) && $past(load_addr) < 13'h1C00;
	endproperty
	a_blk_src: assert property (p_blk_src) else $error("spurious block");
	property p_clr;
		$fell(concurrent_section_busy) |-> $past(store_program_instr);
	endproperty
	a_clr: assert property (p_clr) else $error("busy cleared alone");
	property p_rdata;
		!reg_read |=> reg_rdata == 8'h00;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data not idle");
	c_stall: cover property ($rose(cpu_stall));
	c_busy: cover property ($rose(concurrent_section_busy));
	c_blk: cover property (load_blocked);
endmodule // fspc_ctrl_asserts
bind fspc_ctrl fspc_ctrl_asserts #(.OP_CYCLES(OP_CYCLES)) u_chk (
	.clock(clock), .rst(rst), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.store_program_instr(store_program_instr), .pc_addr(pc_addr),
	.target_addr(target_addr), .load_program_instr(load_program_instr),
	.load_addr(load_addr), .cpu_stall(cpu_stall),
	.concurrent_section_busy(concurrent_section_busy),
	.load_blocked(load_blocked), .program_done(program_done));

// *** verif/fspc_cpu_model.sv ***
// CPU core model issuing store-program and load requests.
// Assumes the bench calls its tasks; drives just after clock edges.
`timescale 1ns/10ps
module fspc_cpu_model (
	input wire logic clock,
	input wire logic busy,
	output logic store_program_instr,
	output logic [12:0] pc_addr,
	output logic [12:0] target_addr,
	output logic load_program_instr,
	output logic [12:0] load_addr
);
	initial begin
		store_program_instr = 1'b0;
		pc_addr = 13'h0000;
		target_addr = 13'h0000;
		load_program_instr = 1'b0;
		load_addr = 13'h0000;
	end
	task automatic store_prog(input logic [12:0] pc, input logic [12:0] tg);
		@(posedge clock);
		store_program_instr <= 1'b1;
		pc_addr <= pc;
		target_addr <= tg;
		@(posedge clock);
		store_program_instr <= 1'b0;
		pc_addr <= ~pc;
		target_addr <= ~tg;
	endtask
	// Skips blocked-section loads unless told to misbehave
	task automatic ld(input logic [12:0] a, input logic bad);
		if (busy && a < 13'h1C00 && !bad) return;
		@(posedge clock);
		load_program_instr <= 1'b1;
		load_addr <= a;
		@(posedge clock);
		load_program_instr <= 1'b0;
		load_addr <= ~a;
	endtask
endmodule // fspc_cpu_model

// *** verif/flash_self_program_access_control_tb_top.sv ***
// Self-checking bench for fspc_ctrl with a CPU model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
module flash_self_program_access_control_tb_top;
	localparam int OPC = 8;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [1:0] fuses = 2'h3;
	logic [7:0] rdata, rv;
	logic [12:0] store_pc, store_tg, ld_a;
	logic store_i, ld_i, stall, busy, blk, done, irq;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	initial forever #4 clock = ~clock;
	fspc_cpu_model u_cpu (.clock(clock), .busy(busy), .store_program_instr(store_i),
		.pc_addr(store_pc), .target_addr(store_tg), .load_program_instr(ld_i), .load_addr(ld_a));
	fspc_ctrl #(.OP_CYCLES(OPC)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
		.store_program_instr(store_i), .pc_addr(store_pc), .target_addr(store_tg),
		.loader_size_fuses(fuses), .load_program_instr(ld_i), .load_addr(ld_a),
		.cpu_stall(stall), .concurrent_section_busy(busy), .load_blocked(blk),
		.program_done(done), .irq(irq));
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_wdata <= 8'h00;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic [12:0] ldr_base(input logic [1:0] f);
		return (f == 2'h3) ? 13'h1F80 : (f == 2'h2) ? 13'h1F00
			: (f == 2'h1) ? 13'h1E00 : 13'h1C00;
	endfunction
	task automatic halt_op(input logic [12:0] pc);
		wr(3'h0, 8'h03);
		u_cpu.store_prog(pc, 13'h1C00 + 13'($urandom % 1024));
		n = 0;
		#1;
		while (stall === 1'b1 && n < 50) begin
			@(posedge clock);
			#1 n++;
		end
		chk(16'(n), 16'(OPC + 1));
		n = 0;
		while (done !== 1'b1 && n < 3) begin
			@(posedge clock);
			#1 n++;
		end
		chk(16'(done), 16'h0001);
	endtask
	initial begin
		void'($urandom(29453));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		#1 chk({stall, busy, blk, done, irq}, 16'h0000);
		rd(3'h1, rv);
		chk(16'(rv), 16'h000F);
		rd(3'h5, rv);
		chk(16'(rv), 16'h0000);
		$display("test reset done");
		wr(3'h0, 8'h05);
		u_cpu.store_prog(13'($urandom % 6144), 13'($urandom % 7168));
		repeat (2) @(posedge clock);
		#1 chk({stall, busy}, 16'h0000);
		rd(3'h2, rv);
		chk(16'(rv), 16'h0002);
		wr(3'h3, 8'h02);
		repeat (2) @(posedge clock);
		#1 chk(16'(irq), 16'h0001);
		wr(3'h2, 8'h02);
		repeat (2) @(posedge clock);
		#1 chk(16'(irq), 16'h0000);
		$display("test refuse and irq done");
		for (int f = 0; f < 4; f++) begin
			fuses <= 2'(f);
			wr(3'h0, 8'h03);
			u_cpu.store_prog(ldr_base(2'(f)) - 13'h0001, 13'h1C00);
			#1 chk(16'(stall), 16'h0000);
			halt_op(ldr_base(2'(f)));
		end
		$display("test halting ops done");
		for (int k = 0; k < 2; k++) begin
			wr(3'h0, 8'h05);
			u_cpu.store_prog(13'h1F80, 13'($urandom % 7168));
			#1 chk({stall, busy}, 16'h0001);
			u_cpu.ld(13'($urandom % 7168), 1'b1);
			#1 chk(16'(blk), 16'h0001);
			u_cpu.ld(13'h1D00, 1'b0);
			#1 chk(16'(blk), 16'h0000);
			rd(3'h0, rv);
			chk(16'(rv[6]), 16'h0001);
			repeat (OPC + 4) @(posedge clock);
			#1 chk(16'(busy), 16'h0001);
			wr(3'h0, (k == 0) ? 8'h11 : 8'h01);
			u_cpu.store_prog(13'h1F80, 13'h0000);
			repeat (2) @(posedge clock);
			#1 chk(16'(busy), 16'h0000);
		end
		$display("test concurrent ops done");
		// Program the application lock, then a page op there must not start
		wr(3'h0, 8'h09);
		@(posedge clock);
		reg_wdata <= 8'h01;
		u_cpu.store_prog(13'h1F80, 13'h0000);
		reg_wdata <= 8'h00;
		rd(3'h1, rv);
		chk(16'(rv), 16'h000E);
		wr(3'h0, 8'h05);
		u_cpu.store_prog(13'h1F80, 13'h0100);
		repeat (2) @(posedge clock);
		#1 chk({stall, busy}, 16'h0000);
		$display("test lock sets done");
		wrap_up();
	end
endmodule // flash_self_program_access_control_tb_top
